// ===== pbs_params.svh
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// =====================================================
// widths and layout
`define PBS_ADDR_W 18
`define PBS_DEPTH (1 << 18)
`define PBS_LANE_W 9
`define PBS_LANES 2
`define PBS_DATA_W 18
`define PBS_BURST_W 2

// =====================================================
// reset values
`define PBS_ADDR_RST 18'h00000
`define PBS_DATA_RST 18'h00000
`define PBS_BURST_RST 2'h0
`define PBS_LANE_RST 2'h0
`define PBS_STROBE_RST 1'h1
`define PBS_ENABLE_RST 1'h0

// =====================================================
// burst step and lane mask values
`define PBS_BURST_STEP 2'h1
`define PBS_LANES_ALL 2'h3
`define PBS_LANES_NONE 2'h0

`endif

// ===== pbs_pkg.sv
`default_nettype none
`include "pbs_params.svh"

package pbs_pkg;
	typedef logic [`PBS_ADDR_W-1:0] pbs_addr_t;
	typedef logic [`PBS_DATA_W-1:0] pbs_data_t;
	typedef logic [`PBS_LANES-1:0] pbs_lanes_t;
	typedef logic [`PBS_BURST_W-1:0] pbs_burst_t;
	typedef enum logic [0:0] {
		PBS_SEL_OFF = 1'h0,
		PBS_SEL_ON = 1'h1
	} pbs_sel_t;
endpackage

`default_nettype wire

// ===== pbs_array_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pbs_array_if;
	pbs_pkg::pbs_addr_t addr;
	pbs_pkg::pbs_data_t wdata;
	pbs_pkg::pbs_lanes_t we;
	pbs_pkg::pbs_data_t rdata;
	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface

`default_nettype wire

// ===== pbs_array.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module pbs_array (
	// clock
	input wire logic mclk,
	// access port
	pbs_array_if.mem port
);
	// =====================================================
	// storage
	// no reset: array contents are undefined after power-up, like the cell array
	genvar lane;
	generate
		for (lane = 0; lane < `PBS_LANES; lane++) begin : g_lane
			// one array per lane, so each array has a single writing process
			logic [`PBS_LANE_W-1:0] cells [`PBS_DEPTH];
			always_ff @(posedge mclk) begin
				if (port.we[lane]) begin
					cells[port.addr] <= port.wdata[lane*`PBS_LANE_W +: `PBS_LANE_W];
				end
			end
			assign port.rdata[lane*`PBS_LANE_W +: `PBS_LANE_W] = cells[port.addr];
		end
	endgenerate
endmodule

`default_nettype wire

// ===== pbs_access.sv
// Contract
// - every synchronous input is registered on the rising edge; read data is registered
// - an access begins on either address strobe low with chip selects valid
// - read starts with strobe low, selects active, writes idle; processor strobe needs select
// - starting address goes to address register, burst logic and array at once
// - read data is driven after the next rising edge when output enable is low
// - outputs stay off during the first cycle after leaving deselect
// - after a sampled deselect, data drives one more cycle, then releases
// - processor strobe start loads address, ignores write controls and burst advance
// - processor strobe write takes two clocks; global write there writes every byte
// - byte write writes only selected lanes and keeps the others unchanged
// - global write low overrides byte controls and writes all lanes
// - data drivers turn off whenever a write cycle is detected
// - controller strobe write completes in one clock with all controls on one edge
// - controller strobe write loads the full address and ignores burst advance
// - a two-bit wrapping burst counter captures the start and steps onward
// - burst counter starts from the two low address bits, linear or interleaved
// - burst order comes from sampling the static order select input
// - the burst address moves only as the burst advance input directs
// - low lane is the low byte, high lane the high byte, sampled on rising edge
// - order select low gives linear, high gives interleaved
// - burst advance high holds the current burst address
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module pbs_access (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// address and strobes
	input wire logic [`PBS_ADDR_W-1:0] addr,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	// chip selects
	input wire logic primary_chip_select_n,
	input wire logic depth_select_high,
	input wire logic depth_select_low_n,
	// write controls
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [`PBS_LANES-1:0] byte_lane_select_n,
	// asynchronous controls
	input wire logic output_enable_n,
	input wire logic burst_order_sel,
	// common data pins, low lane in the low bits
	input wire logic [`PBS_DATA_W-1:0] data_lane_bus_in,
	output logic [`PBS_DATA_W-1:0] data_lane_bus_out,
	output logic data_lane_bus_oe
);
	// =====================================================
	// lane write decode
	function automatic pbs_pkg::pbs_lanes_t lane_writes(input logic glob_n, input logic gate_n,
		input pbs_pkg::pbs_lanes_t lane_n);
		if (!glob_n) begin
			lane_writes = `PBS_LANES_ALL;
		end else if (!gate_n) begin
			lane_writes = ~lane_n;
		end else begin
			lane_writes = `PBS_LANES_NONE;
		end
	endfunction

	// =====================================================
	// input registers
	pbs_pkg::pbs_addr_t addr_reg;
	pbs_pkg::pbs_data_t din_reg;
	pbs_pkg::pbs_lanes_t lane_n_reg;
	// write controls are kept raw; the decode decides what they mean
	logic pstrobe_n_reg;
	logic cstrobe_n_reg;
	logic advance_n_reg;
	logic glob_wr_n_reg;
	logic gate_n_reg;
	logic sel1_n_reg;
	logic sel2_reg;
	logic sel3_n_reg;
	// two-stage synchronisers for the asynchronous pins
	logic oe_meta_reg;
	logic oe_sync_reg;
	logic mode_meta_reg;
	logic mode_sync_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addr_reg <= `PBS_ADDR_RST;
			din_reg <= `PBS_DATA_RST;
			lane_n_reg <= `PBS_LANES_ALL;
			pstrobe_n_reg <= `PBS_STROBE_RST;
			cstrobe_n_reg <= `PBS_STROBE_RST;
			advance_n_reg <= `PBS_STROBE_RST;
			glob_wr_n_reg <= `PBS_STROBE_RST;
			gate_n_reg <= `PBS_STROBE_RST;
			sel1_n_reg <= `PBS_STROBE_RST;
			sel2_reg <= `PBS_ENABLE_RST;
			sel3_n_reg <= `PBS_STROBE_RST;
			oe_meta_reg <= `PBS_STROBE_RST;
			oe_sync_reg <= `PBS_STROBE_RST;
			mode_meta_reg <= `PBS_STROBE_RST;
			mode_sync_reg <= `PBS_STROBE_RST;
		end else begin
			addr_reg <= addr;
			din_reg <= data_lane_bus_in;
			lane_n_reg <= byte_lane_select_n;
			pstrobe_n_reg <= processor_addr_strobe_n;
			cstrobe_n_reg <= controller_addr_strobe_n;
			advance_n_reg <= burst_advance_n;
			glob_wr_n_reg <= global_write_n;
			gate_n_reg <= byte_write_gate_n;
			sel1_n_reg <= primary_chip_select_n;
			sel2_reg <= depth_select_high;
			sel3_n_reg <= depth_select_low_n;
			// asynchronous pins: costs two cycles of output enable latency
			oe_meta_reg <= output_enable_n;
			oe_sync_reg <= oe_meta_reg;
			mode_meta_reg <= burst_order_sel;
			mode_sync_reg <= mode_meta_reg;
		end
	end

	// =====================================================
	// access decode
	pbs_array_if mem_if ();

	pbs_array pbs_array_i (
		.mclk(mclk),
		.port(mem_if)
	);

	pbs_pkg::pbs_sel_t sel_reg;
	pbs_pkg::pbs_sel_t sel_next;
	pbs_pkg::pbs_addr_t cur_addr_reg;
	pbs_pkg::pbs_addr_t cur_addr_next;
	pbs_pkg::pbs_addr_t use_addr;
	pbs_pkg::pbs_burst_t base_reg;
	pbs_pkg::pbs_burst_t base_next;
	pbs_pkg::pbs_burst_t step_reg;
	pbs_pkg::pbs_burst_t step_next;
	pbs_pkg::pbs_burst_t step_use;
	pbs_pkg::pbs_data_t dout_reg;
	pbs_pkg::pbs_data_t dout_next;
	pbs_pkg::pbs_lanes_t lanes;
	logic rd_valid_reg;
	logic rd_valid_next;
	logic cs_ok;
	logic start_p;
	logic start_c;
	logic begin_acc;
	logic desel;
	logic cont;
	logic is_write;
	logic is_read;

	always_comb begin
		cs_ok = !sel1_n_reg && sel2_reg && !sel3_n_reg;
		// processor strobe only counts with the primary select low
		start_p = !pstrobe_n_reg && !sel1_n_reg;
		start_c = !start_p && !cstrobe_n_reg;
		begin_acc = (start_p || start_c) && cs_ok;
		desel = (start_p || start_c) && !cs_ok;
		cont = !start_p && cstrobe_n_reg && sel_reg == pbs_pkg::PBS_SEL_ON;
		// first cycle of a processor strobe access is always a read
		lanes = start_p ? `PBS_LANES_NONE :
			lane_writes(glob_wr_n_reg, gate_n_reg, lane_n_reg);
		is_write = (begin_acc || cont) && lanes != `PBS_LANES_NONE;
		is_read = (begin_acc || cont) && !is_write;
		// a continue write lands on the advanced address, as a continue read does;
		// advance high leaves the step, so a processor write hits its start address
		step_use = (cont && !advance_n_reg) ?
			step_reg + `PBS_BURST_STEP : step_reg;
		if (begin_acc) begin
			use_addr = addr_reg;
		end else if (!mode_sync_reg) begin
			use_addr = {cur_addr_reg[`PBS_ADDR_W-1:`PBS_BURST_W], base_reg + step_use};
		end else begin
			use_addr = {cur_addr_reg[`PBS_ADDR_W-1:`PBS_BURST_W], base_reg ^ step_use};
		end
	end

	assign mem_if.addr = use_addr;
	assign mem_if.wdata = din_reg;
	assign mem_if.we = is_write ? lanes : `PBS_LANES_NONE;

	// =====================================================
	// burst and output state
	always_comb begin
		sel_next = sel_reg;
		cur_addr_next = cur_addr_reg;
		base_next = base_reg;
		step_next = step_reg;
		dout_next = dout_reg;
		rd_valid_next = 1'h0;
		if (begin_acc) begin
			sel_next = pbs_pkg::PBS_SEL_ON;
			cur_addr_next = addr_reg;
			base_next = addr_reg[`PBS_BURST_W-1:0];
			step_next = `PBS_BURST_RST;
		end else if (desel) begin
			sel_next = pbs_pkg::PBS_SEL_OFF;
		end else if (cont) begin
			cur_addr_next = use_addr;
			step_next = step_use;
		end
		if (is_read) begin
			dout_next = mem_if.rdata;
			rd_valid_next = 1'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel_reg <= pbs_pkg::PBS_SEL_OFF;
			cur_addr_reg <= `PBS_ADDR_RST;
			base_reg <= `PBS_BURST_RST;
			step_reg <= `PBS_BURST_RST;
			dout_reg <= `PBS_DATA_RST;
			rd_valid_reg <= 1'h0;
		end else begin
			sel_reg <= sel_next;
			cur_addr_reg <= cur_addr_next;
			base_reg <= base_next;
			step_reg <= step_next;
			dout_reg <= dout_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// =====================================================
	// data drivers
	// read data is only valid one edge after the access, so a fresh selection stays off
	// relies on the controller raising output enable before it drives write data
	assign data_lane_bus_oe = rd_valid_reg && !oe_sync_reg && !is_write;
	assign data_lane_bus_out = dout_reg;

	// =====================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// the registered pins are decoded one edge after the pins themselves
	input_reg_a: assert property (addr_reg == $past(addr))
		else $error("address not registered on the edge");
	start_gate_a: assert property ((!pstrobe_n_reg && sel1_n_reg && cstrobe_n_reg)
		|-> !begin_acc)
		else $error("processor strobe began access without primary select");
	read_start_a: assert property ((start_c && cs_ok && glob_wr_n_reg && gate_n_reg)
		|=> rd_valid_reg)
		else $error("idle write controls did not start a read");
	start_load_a: assert property (begin_acc |=> cur_addr_reg == $past(addr_reg))
		else $error("start address not loaded");
	read_out_a: assert property ((is_read && !oe_sync_reg) ##1
		(!is_write && !oe_sync_reg) |-> data_lane_bus_oe)
		else $error("read data not driven after next edge");
	fresh_off_a: assert property ((sel_reg == pbs_pkg::PBS_SEL_OFF && begin_acc)
		|-> !data_lane_bus_oe)
		else $error("drivers on in first cycle from deselect");
	desel_drive_a: assert property ((desel && rd_valid_reg && !oe_sync_reg)
		|-> data_lane_bus_oe)
		else $error("data dropped in the cycle of a deselect");
	desel_release_a: assert property (desel |=> !data_lane_bus_oe)
		else $error("drivers not released after deselect");
	proc_ignore_a: assert property (start_p |-> mem_if.we == `PBS_LANES_NONE)
		else $error("write in processor strobe first cycle");
	proc_start_a: assert property ((start_p && cs_ok) |=> step_reg == 2'h0)
		else $error("burst advanced in processor strobe first cycle");
	global_write_a: assert property ((cont && !glob_wr_n_reg)
		|-> mem_if.we == `PBS_LANES_ALL)
		else $error("global write missed a lane");
	byte_write_a: assert property ((cont && glob_wr_n_reg && !gate_n_reg)
		|-> mem_if.we == ~lane_n_reg)
		else $error("byte write lanes wrong");
	write_hiz_a: assert property ((mem_if.we != `PBS_LANES_NONE) |-> !data_lane_bus_oe)
		else $error("drivers on during write");
	ctrl_write_a: assert property ((start_c && cs_ok && !glob_wr_n_reg)
		|-> mem_if.we == `PBS_LANES_ALL)
		else $error("controller strobe write not done in its cycle");
	full_load_a: assert property (begin_acc |-> mem_if.addr == addr_reg)
		else $error("start cycle did not use the full address");
	base_load_a: assert property (begin_acc |=> base_reg == $past(addr_reg[1:0]))
		else $error("burst start not taken from low address bits");
	burst_step_a: assert property ((cont && !advance_n_reg)
		|=> step_reg == $past(step_reg) + 2'h1)
		else $error("burst counter did not advance");
	step_hold_a: assert property ((cont && advance_n_reg) |=> $stable(step_reg))
		else $error("burst counter moved while advance high");
	burst_hold_a: assert property ((cont && advance_n_reg) |=> $stable(cur_addr_reg))
		else $error("burst moved while advance high");
	linear_step_a: assert property ((cont && !advance_n_reg && !mode_sync_reg) |=>
		cur_addr_reg[1:0] == $past(cur_addr_reg[1:0]) + 2'h1)
		else $error("linear burst step wrong");
	interleave_a: assert property ((cont && !advance_n_reg && mode_sync_reg) |=>
		cur_addr_reg[1:0] == ($past(base_reg) ^ ($past(step_reg) + 2'h1)))
		else $error("interleaved burst address wrong");

	// =====================================================
	// coverage
	read_start_c: cover property (is_read ##1 data_lane_bus_oe);
	ctrl_write_c: cover property (start_c && is_write);
	proc_write_c: cover property (start_p && begin_acc ##1 (cont && is_write));
	burst_wrap_c: cover property ((cont && !advance_n_reg) [*4]);
	desel_hold_c: cover property (desel && data_lane_bus_oe);
endmodule

`default_nettype wire

// ===== pbs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module pbs_host_model (
	// clock
	input wire logic mclk,
	// address and control pins
	output var logic [`PBS_ADDR_W-1:0] addr,
	output var logic processor_addr_strobe_n,
	output var logic controller_addr_strobe_n,
	output var logic burst_advance_n,
	output var logic primary_chip_select_n,
	output var logic depth_select_high,
	output var logic depth_select_low_n,
	output var logic global_write_n,
	output var logic byte_write_gate_n,
	output var logic [`PBS_LANES-1:0] byte_lane_select_n,
	output var logic output_enable_n,
	output var logic burst_order_sel,
	// data the host puts on the shared pins
	output var logic [`PBS_DATA_W-1:0] data_drv
);
	logic oe_req;
	logic order_req;

	initial begin
		oe_req = 1'h1;
		order_req = 1'h1;
		apply_now(0, 18'h00000, 18'h00000, 2'h3);
	end

	// =====================================================
	// bus cycles
	// kinds: 0 8 9 deselect, 1 read, 2 global write, 3 byte write, 4 processor start,
	// 5 continue, 6 continue with global write, 7 suspend, 10 processor strobe unselected
	task automatic apply_now(input int k, input pbs_pkg::pbs_addr_t a,
		input pbs_pkg::pbs_data_t d, input pbs_pkg::pbs_lanes_t bw);
		output_enable_n <= oe_req;
		burst_order_sel <= order_req;
		addr <= a;
		primary_chip_select_n <= (k == 0 || k == 10);
		depth_select_high <= (k != 8);
		depth_select_low_n <= (k == 9);
		processor_addr_strobe_n <= !(k == 4 || k == 10);
		controller_addr_strobe_n <= !(k inside {0, 1, 2, 3, 8, 9});
		// write controls live on a processor start, the device must drop them
		burst_advance_n <= !(k == 4 || k == 5);
		global_write_n <= !(k == 2 || k == 4 || k == 6);
		byte_write_gate_n <= !(k inside {2, 3, 4});
		byte_lane_select_n <= (k == 4) ? 2'h0 : bw;
		// released pins toggle so a stale value can never look like read data
		data_drv <= (oe_req && k inside {2, 3, 4, 6}) ? d : ~data_drv;
	endtask

	task automatic apply(input int k, input pbs_pkg::pbs_addr_t a,
		input pbs_pkg::pbs_data_t d, input pbs_pkg::pbs_lanes_t bw);
		@(posedge mclk);
		apply_now(k, a, d, bw);
	endtask
endmodule

`default_nettype wire

// ===== pbs_access_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module pbs_access_bench;
	localparam pbs_pkg::pbs_addr_t base_addr = 18'h2b3c0;
	logic mclk;
	logic rst;
	logic [`PBS_ADDR_W-1:0] addr;
	logic pstb_n, cstb_n, advance_n, cs1_n, cs2, cs3_n, glob_n, gate_n, oe_n, order;
	logic [`PBS_LANES-1:0] bw_n;
	logic [`PBS_DATA_W-1:0] data_drv, bus_out, bus_in;
	logic bus_oe;
	int n_mismatch, compares;
	int chk_q[2];
	pbs_pkg::pbs_data_t exp_q[2];
	pbs_pkg::pbs_data_t ref_mem[4];

	assign bus_in = bus_oe ? bus_out : data_drv;

	pbs_host_model pbs_host_model_i (.mclk(mclk), .addr(addr),
		.processor_addr_strobe_n(pstb_n), .controller_addr_strobe_n(cstb_n),
		.burst_advance_n(advance_n), .primary_chip_select_n(cs1_n), .depth_select_high(cs2),
		.depth_select_low_n(cs3_n), .global_write_n(glob_n), .byte_write_gate_n(gate_n),
		.byte_lane_select_n(bw_n), .output_enable_n(oe_n), .burst_order_sel(order),
		.data_drv(data_drv));

	pbs_access pbs_access_i (.mclk(mclk), .rst(rst), .addr(addr),
		.processor_addr_strobe_n(pstb_n), .controller_addr_strobe_n(cstb_n),
		.burst_advance_n(advance_n), .primary_chip_select_n(cs1_n), .depth_select_high(cs2),
		.depth_select_low_n(cs3_n), .global_write_n(glob_n), .byte_write_gate_n(gate_n),
		.byte_lane_select_n(bw_n), .output_enable_n(oe_n), .burst_order_sel(order),
		.data_lane_bus_in(bus_in), .data_lane_bus_out(bus_out), .data_lane_bus_oe(bus_oe));

	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// =====================================================
	// one cycle; c 1 expects data two edges later, c 2 expects drivers off
	task automatic step(input int k, input pbs_pkg::pbs_addr_t a, input pbs_pkg::pbs_data_t d,
		input int c, input pbs_pkg::pbs_data_t e, input pbs_pkg::pbs_lanes_t bw = 2'h3);
		pbs_host_model_i.apply(k, a, d, bw);
		#1;
		if (chk_q[1] != 0) begin
			compares++;
			if (bus_oe !== ((chk_q[1] == 1) ? 1'h1 : 1'h0) ||
				(chk_q[1] == 1 && bus_out !== exp_q[1])) begin
				n_mismatch++;
				$display("[ERR] %0t oe %b data %h expected %h", $time, bus_oe, bus_out, exp_q[1]);
			end
		end
		chk_q[1] = chk_q[0];
		exp_q[1] = exp_q[0];
		chk_q[0] = c;
		exp_q[0] = e;
	endtask

	task automatic idle(input int n);
		repeat (n) step(0, 18'h00000, 18'h00000, 2, 18'h00000);
	endtask

	task automatic set_oe(input logic v);
		pbs_host_model_i.oe_req = v;
		idle(3);
	endtask

	// =====================================================
	// scenarios
	task automatic t_write_read;
		set_oe(1'h1);
		for (int i = 0; i < 4; i++) begin
			ref_mem[i] = {9'h1a0 + 9'(i), 9'h0c0 + 9'(i)};
			step(2, base_addr + 18'(i), ref_mem[i], 2, 18'h00000);
		end
		set_oe(1'h0);
		for (int i = 0; i < 4; i++) step(1, base_addr + 18'(i), 18'h0, 1, ref_mem[i]);
		$display("test write_read done");
	endtask

	task automatic t_byte_proc;
		set_oe(1'h1);
		ref_mem[0][8:0] = 9'h1ff;
		step(3, base_addr, 18'h3ffff, 2, 18'h00000, 2'h2);
		ref_mem[1][17:9] = 9'h000;
		step(3, base_addr + 18'h1, 18'h00000, 2, 18'h00000, 2'h1);
		step(4, base_addr + 18'h3, 18'h0aaaa, 2, 18'h00000);
		ref_mem[3] = 18'h15555;
		step(6, 18'h00000, 18'h15555, 2, 18'h00000);
		set_oe(1'h0);
		step(1, base_addr, 18'h0, 1, ref_mem[0]);
		step(1, base_addr + 18'h1, 18'h0, 1, ref_mem[1]);
		step(1, base_addr + 18'h3, 18'h0, 1, ref_mem[3]);
		$display("test byte_proc done");
	endtask

	task automatic t_burst(input logic ord, input pbs_pkg::pbs_burst_t s);
		pbs_pkg::pbs_burst_t b;
		pbs_host_model_i.order_req = ord;
		idle(3);
		step(1, base_addr + 18'(s), 18'h0, 1, ref_mem[s]);
		b = s;
		for (int i = 1; i < 4; i++) begin
			b = ord ? (s ^ 2'(i)) : (s + 2'(i));
			step(5, 18'h00000, 18'h0, 1, ref_mem[b]);
		end
		step(7, 18'h00000, 18'h0, 1, ref_mem[b]);
		idle(2);
		$display("test burst order %b done", ord);
	endtask

	task automatic t_select;
		step(1, base_addr, 18'h0, 1, ref_mem[0]);
		step(0, 18'h00000, 18'h0, 2, 18'h0);
		step(1, base_addr + 18'h1, 18'h0, 1, ref_mem[1]);
		step(8, 18'h00000, 18'h0, 2, 18'h0);
		step(1, base_addr + 18'h2, 18'h0, 1, ref_mem[2]);
		step(9, 18'h00000, 18'h0, 2, 18'h0);
		step(10, base_addr, 18'h0, 2, 18'h0);
		step(4, base_addr + 18'h3, 18'h0aaaa, 1, ref_mem[3]);
		idle(2);
		set_oe(1'h1);
		step(1, base_addr, 18'h0, 2, 18'h0);
		set_oe(1'h0);
		$display("test select done");
	endtask

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// a hung run still ends through the verdict
	initial begin
		#100000;
		n_mismatch++;
		$display("[ERR] %0t run limit reached", $time);
		end_of_test();
	end

	initial begin
		rst = 1'h1;
		n_mismatch = 0;
		compares = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'h0;
		idle(3);
		t_write_read();
		t_byte_proc();
		t_burst(1'h0, 2'h2);
		t_burst(1'h1, 2'h1);
		t_select();
		idle(2);
		end_of_test();
	end
endmodule

`default_nettype wire
